// File: common/pmp_pkg.sv
// holds constants and carrier types for the phone mcu port pin logic
// assumes a single 250 MHz clock and synchronous pin inputs
package pmp_pkg;
   // ************************************
   // widths
   // ************************************
   localparam int WAKE_W    = 8;
   localparam int NIB_W     = 8;
   localparam int NIB_GRP   = 4;
   localparam int NIB_CNT   = NIB_W / NIB_GRP;
   localparam int MIX_W     = 8;
   // ************************************
   // mixed-port bit positions
   // ************************************
   localparam int POS_FALL_A  = 0;
   localparam int POS_AUDIO   = 1;
   localparam int POS_OD_A    = 2;
   localparam int POS_OD_B    = 3;
   localparam int POS_FALL_B  = 5;
   localparam int POS_RISE    = 7;
   // ************************************
   // reset values
   // ************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic       RST_BIT  = 1'b0;

   typedef struct packed {
      logic [7:0] dirOut;   // 1 = pin drives
      logic [7:0] outVal;
      logic [7:0] pullEn;
   } pmp_cfg_t;

   typedef struct packed {
      logic [7:0] outVal;
      logic [7:0] outEn_b;  // low while driving
      logic [7:0] pullOn;
   } pmp_pad_t;

   typedef enum logic [2:0] {
      PWR_RUN   = 3'b001,
      PWR_IDLE  = 3'b010,
      PWR_DOWN  = 3'b100
   } pmp_pwr_t;
endpackage

// File: logic/pmp_edge_det.sv
// holds one synchronise-and-compare edge detector
// assumes input already past the schmitt receiver
module pmp_edge_det
   import pmp_pkg::*;
#(
   parameter bit RISING = 1'b0
) (
   input  wire logic clk,
   input  wire logic rstSync_b,
   input  wire logic pinIn,
   output logic      edgeSeen
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic [2:0] fill;
   } pmp_edge_st_t;

   pmp_edge_st_t st_r;
   pmp_edge_st_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.s1   = pinIn;
      st_nxt.s2   = st_r.s1;
      st_nxt.prev = st_r.s2;
      st_nxt.fill = {st_r.fill[1:0], 1'b1};
   end

   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         st_r <= '{s1: 1'b1 ^ RISING, s2: 1'b1 ^ RISING, prev: 1'b1 ^ RISING, fill: 3'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // compare synced sample to the previous one, s1 not looked at
   // pin idle level is unknown at reset: no edge until prev holds a real sample
   assign edgeSeen = st_r.fill[2] & (RISING ? (st_r.s2 & ~st_r.prev) : (~st_r.s2 & st_r.prev));
endmodule

// File: logic/pmp_port_pins.sv
// holds the pin logic of the wake, mixed and nibble-pullup ports
// assumes synchronous pin inputs and an outside core holding cfg bits
// What this block does
// - each wake port pin set as input optionally wakes power-down on a fall
// - software sets direction; push-pull out, schmitt in
// - per-pin pull-high on wake and mixed ports, none on the two open-drain lines
// - nibble port pull-high per four-pin nibble
// - enabled interrupt on two falls, one rise
// - pin-edge interrupt wakes device from idle
// - two open-drain lines only pull low
// - audio pin may carry dac output instead
module pmp_port_pins
   import pmp_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   // wake-capable port
   input  wire pmp_pkg::pmp_cfg_t  wakeCfg,
   input  wire logic [7:0]         wakeOptEn,
   input  wire logic [7:0]         wake_capable_port_pins_in,
   output pmp_pkg::pmp_pad_t       wakePad,
   output logic [7:0]              wakeRdData,
   // mixed port
   input  wire pmp_pkg::pmp_cfg_t  mixCfg,
   input  wire logic               audioSel,
   input  wire logic               audioDacBit,
   input  wire logic [7:0]         mixPinsIn,
   output pmp_pkg::pmp_pad_t       mixPad,
   output logic [7:0]              mixRdData,
   // nibble-pullup port
   input  wire pmp_pkg::pmp_cfg_t  nibCfg,
   input  wire logic [1:0]         nibPullOpt,
   input  wire logic [7:0]         nibble_pullup_port_pins_in,
   output pmp_pkg::pmp_pad_t       nibPad,
   output logic [7:0]              nibRdData,
   // interrupt and power
   input  wire logic               mfIntEn,
   input  wire logic               mfIntClr,
   input  wire logic               enterIdle,
   input  wire logic               enterDown,
   output logic                    mfIntReq,
   output logic                    wakeUp,
   output pmp_pkg::pmp_pwr_t       pwrState
);
   // ************************************
   // reset release
   // ************************************
   logic rstMeta_r;
   logic rstSync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_r <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_b <= rstMeta_r;
      end
   end

   // ************************************
   // elaboration checks
   // ************************************
   // ports are fixed at one byte, so the package widths must agree
   if (WAKE_W != 8 || MIX_W != 8 || NIB_W != 8) begin : gWidthCheck
      $error("pin port width must be eight");
   end
   // two option bits, so exactly two four-pin groups
   if (NIB_GRP * NIB_CNT != NIB_W || NIB_CNT != 2) begin : gNibCheck
      $error("nibble pull option needs two groups of four");
   end

   // ************************************
   // state
   // ************************************
   typedef struct packed {
      pmp_pad_t   wake;
      pmp_pad_t   mix;
      pmp_pad_t   nib;
      logic [7:0] wakeRd;
      logic [7:0] mixRd;
      logic [7:0] nibRd;
      logic [7:0] wakePrev;
      logic       intReq;
      logic       wakePulse;
      pmp_pwr_t   pwr;
   } pmp_state_t;

   pmp_state_t st_r;
   pmp_state_t st_nxt;

   // ************************************
   // edge detectors
   // ************************************
   logic fallA;
   logic fallB;
   logic riseC;

   pmp_edge_det #(.RISING(1'b0)) uFallA (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .pinIn     (mixPinsIn[POS_FALL_A]),
      .edgeSeen  (fallA)
   );
   pmp_edge_det #(.RISING(1'b0)) uFallB (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .pinIn     (mixPinsIn[POS_FALL_B]),
      .edgeSeen  (fallB)
   );
   pmp_edge_det #(.RISING(1'b1)) uRise (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .pinIn     (mixPinsIn[POS_RISE]),
      .edgeSeen  (riseC)
   );

   // ************************************
   // pad helpers
   // ************************************
   // push-pull pad drive from direction and value
   function automatic pmp_pad_t drivePad(input pmp_cfg_t c, input logic [7:0] pull);
      pmp_pad_t p;
      p.outVal  = c.outVal;
      p.outEn_b = ~c.dirOut;
      p.pullOn  = pull & ~c.dirOut;  // pull only matters on inputs
      return p;
   endfunction

   // input view: driven pins read back the latch, others the schmitt input
   function automatic logic [7:0] readPins(input pmp_cfg_t c, input logic [7:0] pins);
      return (c.dirOut & c.outVal) | (~c.dirOut & pins);
   endfunction

   // ************************************
   // next state
   // ************************************
   logic pinEvent;
   logic [7:0] wakeFall;

   always_comb begin
      st_nxt = st_r;
      st_nxt.wake = drivePad(wakeCfg, wakeCfg.pullEn);
      st_nxt.mix  = drivePad(mixCfg, mixCfg.pullEn);
      // one option bit per nibble
      st_nxt.nib  = drivePad(nibCfg, {{NIB_GRP{nibPullOpt[1]}}, {NIB_GRP{nibPullOpt[0]}}});
      // open-drain: low or released, never high, no pull
      st_nxt.mix.outVal[POS_OD_A]  = 1'b0;
      st_nxt.mix.outVal[POS_OD_B]  = 1'b0;
      st_nxt.mix.outEn_b[POS_OD_A] = mixCfg.outVal[POS_OD_A];
      st_nxt.mix.outEn_b[POS_OD_B] = mixCfg.outVal[POS_OD_B];
      st_nxt.mix.pullOn[POS_OD_A]  = 1'b0;
      st_nxt.mix.pullOn[POS_OD_B]  = 1'b0;
      // dac stream overrides the port bit
      if (audioSel) begin
         st_nxt.mix.outVal[POS_AUDIO]  = audioDacBit;
         st_nxt.mix.outEn_b[POS_AUDIO] = 1'b0;
         st_nxt.mix.pullOn[POS_AUDIO]  = 1'b0;
      end
      st_nxt.wakeRd = readPins(wakeCfg, wake_capable_port_pins_in);
      st_nxt.mixRd  = readPins(mixCfg, mixPinsIn);
      // output-only lines read their latch, not the wire
      st_nxt.mixRd[POS_OD_A] = mixCfg.outVal[POS_OD_A];
      st_nxt.mixRd[POS_OD_B] = mixCfg.outVal[POS_OD_B];
      st_nxt.nibRd  = readPins(nibCfg, nibble_pullup_port_pins_in);
      st_nxt.wakePrev = wake_capable_port_pins_in;
      // set wins over clear
      pinEvent = mfIntEn & (fallA | fallB | riseC);
      if (pinEvent) begin
         st_nxt.intReq = 1'b1;
      end else if (mfIntClr) begin
         st_nxt.intReq = 1'b0;
      end
      wakeFall = st_r.wakePrev & ~wake_capable_port_pins_in & wakeOptEn & ~wakeCfg.dirOut;
      st_nxt.wakePulse = 1'b0;
      case (st_r.pwr)
         PWR_RUN: begin
            if (enterDown) begin
               st_nxt.pwr = PWR_DOWN;
            end else if (enterIdle) begin
               st_nxt.pwr = PWR_IDLE;
            end
         end
         PWR_IDLE: begin
            if (pinEvent) begin
               st_nxt.pwr       = PWR_RUN;
               st_nxt.wakePulse = 1'b1;
            end
         end
         PWR_DOWN: begin
            if (|wakeFall) begin
               st_nxt.pwr       = PWR_RUN;
               st_nxt.wakePulse = 1'b1;
            end
         end
         default: begin
            st_nxt.pwr = PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         st_r.wake     <= '{outVal: RST_BYTE, outEn_b: ~RST_BYTE, pullOn: RST_BYTE};
         st_r.mix      <= '{outVal: RST_BYTE, outEn_b: ~RST_BYTE, pullOn: RST_BYTE};
         st_r.nib      <= '{outVal: RST_BYTE, outEn_b: ~RST_BYTE, pullOn: RST_BYTE};
         st_r.wakeRd   <= RST_BYTE;
         st_r.mixRd    <= RST_BYTE;
         st_r.nibRd    <= RST_BYTE;
         st_r.wakePrev <= ~RST_BYTE;
         st_r.intReq   <= RST_BIT;
         st_r.wakePulse <= RST_BIT;
         st_r.pwr      <= PWR_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign wakePad    = st_r.wake;
   assign mixPad     = st_r.mix;
   assign nibPad     = st_r.nib;
   assign wakeRdData = st_r.wakeRd;
   assign mixRdData  = st_r.mixRd;
   assign nibRdData  = st_r.nibRd;
   assign mfIntReq   = st_r.intReq;
   assign wakeUp     = st_r.wakePulse;
   assign pwrState   = st_r.pwr;
endmodule

// File: bench/pmp_port_pins_asserts.sv
// checker on the top ports of the pin block
// assumes one clock and the bind below
module pmp_port_pins_asserts
   import pmp_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_b,
   input wire pmp_pkg::pmp_pad_t mixPad,
   input wire pmp_pkg::pmp_pad_t nibPad,
   input wire logic [1:0]        nibPullOpt,
   input wire logic              audioSel,
   input wire logic              audioDacBit,
   input wire logic [7:0]        mixPinsIn,
   input wire logic              mfIntEn,
   input wire logic              mfIntReq,
   input wire logic              wakeUp,
   input wire pmp_pkg::pmp_pwr_t pwrState
);
   logic [1:0] upCnt_r;
   logic       live;
   // outputs lag the released reset by three edges: two sync flops, then the state register
   always_ff @(posedge clk or negedge rst_b) upCnt_r <= !rst_b ? 2'h0 : upCnt_r + {1'b0, upCnt_r != 2'h3};
   assign live = upCnt_r == 2'h3;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b || !live);
   a_od_low_only: assert property (mixPad.outVal[3:2] == 2'h0) else $error("od high");
   a_nib_pull: assert property (
      nibPad.pullOn == ({{4{$past(nibPullOpt[1])}}, {4{$past(nibPullOpt[0])}}} & nibPad.outEn_b)) else $error("nib pull");
   a_audio_route: assert property (
      $past(audioSel) |-> mixPad.outVal[1] == $past(audioDacBit)) else $error("audio");
   a_rise_irq: assert property (mfIntEn && $rose(mixPinsIn[7]) |-> ##[1:4] mfIntReq) else $error("rise");
   a_fall_irq: assert property (mfIntEn && $fell(mixPinsIn[0]) |-> ##[1:4] mfIntReq) else $error("fall");
   a_irq_gated: assert property (
      $rose(mfIntReq) |-> $past(mfIntEn) || $past(mfIntEn, 2)) else $error("gated");
   a_idle_wake: assert property (
      $rose(mfIntReq) && $past(pwrState) == PWR_IDLE |-> wakeUp && pwrState == PWR_RUN) else $error("idle");
   a_wake_pulse: assert property (wakeUp |=> !wakeUp) else $error("wake pulse");
   c_wake: cover property (wakeUp);
   c_down: cover property (pwrState == PWR_DOWN);
   c_irq: cover property ($rose(mfIntReq));
endmodule
bind pmp_port_pins pmp_port_pins_asserts pmp_port_pins_asserts_inst (.clk(clk), .rst_b(rst_b),
   .mixPad(mixPad), .nibPad(nibPad), .nibPullOpt(nibPullOpt), .audioSel(audioSel),
   .audioDacBit(audioDacBit), .mixPinsIn(mixPinsIn), .mfIntEn(mfIntEn), .mfIntReq(mfIntReq),
   .wakeUp(wakeUp), .pwrState(pwrState));

// File: bench/pmp_board_model.sv
// board side of one 8-pin port
// assumes the bench says which lines the board drives
module pmp_board_model
   import pmp_pkg::*;
(
   input  wire logic              clk,
   input  wire pmp_pkg::pmp_pad_t pad,
   input  wire logic [7:0]        extDrv,
   input  wire logic [7:0]        extVal,
   output logic [7:0]             pinLvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_r = 8'h00;
   always_ff @(posedge clk) last_r <= pinLvl;
   // undriven, unpulled lines float: toggle so no value is trusted
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pad.outEn_b[i]) pinLvl[i] = pad.outVal[i];
         else if (extDrv[i]) pinLvl[i] = extVal[i];
         else if (pad.pullOn[i]) pinLvl[i] = 1'b1;
         else pinLvl[i] = ~last_r[i];
      end
   end
endmodule

// File: bench/test_phone_mcu_port_pins.sv
// self-checking bench for the port pin block
// assumes board models close each pad loop
module test_phone_mcu_port_pins;
   import pmp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, audioSel = 1'b0, audioDacBit = 1'b0, mfIntEn = 1'b0, mfIntClr = 1'b0;
   logic enterIdle = 1'b0, enterDown = 1'b0, mfIntReq, wakeUp;
   logic [1:0] nibPullOpt = 2'h0;
   logic [7:0] wakeOptEn = 8'h00, wakeExt = 8'hff, mixExt = 8'hff, wakeIn, mixIn, nibIn, wakeRd, mixRd, nibRd;
   pmp_cfg_t wakeCfg = '0, mixCfg = '0, nibCfg = '0;
   pmp_pad_t wakePad, mixPad, nibPad;
   pmp_pwr_t pwrState;
   int fail_count = 0, total_checks = 0;
   always #2 clk = ~clk;
   pmp_port_pins pmp_port_pins_inst (.clk(clk), .rst_b(rst_b), .wakeCfg(wakeCfg), .wakeOptEn(wakeOptEn),
      .wake_capable_port_pins_in(wakeIn), .wakePad(wakePad), .wakeRdData(wakeRd), .mixCfg(mixCfg),
      .audioSel(audioSel), .audioDacBit(audioDacBit), .mixPinsIn(mixIn), .mixPad(mixPad), .mixRdData(mixRd),
      .nibCfg(nibCfg), .nibPullOpt(nibPullOpt), .nibble_pullup_port_pins_in(nibIn), .nibPad(nibPad),
      .nibRdData(nibRd), .mfIntEn(mfIntEn), .mfIntClr(mfIntClr), .enterIdle(enterIdle), .enterDown(enterDown),
      .mfIntReq(mfIntReq), .wakeUp(wakeUp), .pwrState(pwrState));
   pmp_board_model wake_board (.clk(clk), .pad(wakePad), .extDrv(8'hff), .extVal(wakeExt), .pinLvl(wakeIn));
   pmp_board_model mix_board (.clk(clk), .pad(mixPad), .extDrv(8'hff), .extVal(mixExt), .pinLvl(mixIn));
   // nothing on the board drives this port: only the pull option lifts a pin
   pmp_board_model nib_board (.clk(clk), .pad(nibPad), .extDrv(8'h00), .extVal(mixExt), .pinLvl(nibIn));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic edge_irq(input logic [7:0] nv, input logic exp);
      mixExt = nv;
      cyc(6);
      cmp(8'(mfIntReq), 8'(exp));
      mfIntClr = 1'b1;
      cyc(1);
      mfIntClr = 1'b0;
      cyc(1);
   endtask
   task automatic wait_wake;
      int n;
      n = 0;
      while (wakeUp !== 1'b1) begin
         @(posedge clk) #1;
         if (++n > 20) begin
            fail_count++;
            final_report;
         end
      end
      cmp(8'(pwrState), 8'(PWR_RUN));
      cyc(1);
   endtask
   initial begin
      cyc(20);
      rst_b = 1'b1;
      cyc(4);
      cmp(wakePad.outEn_b, 8'hff);
      wakeCfg = '{8'h0f, 8'h05, 8'ha0};
      wakeExt = 8'h3f;
      cyc(5);
      cmp(wakePad.outEn_b, 8'hf0);
      cmp(wakePad.pullOn, 8'ha0);
      cmp(wakeRd, 8'h35);
      for (int i = 0; i < 4; i++) begin
         nibPullOpt = 2'(i);
         cyc(2);
         cmp(nibPad.pullOn, {{4{nibPullOpt[1]}}, {4{nibPullOpt[0]}}});
         cmp(nibRd & {{4{nibPullOpt[1]}}, {4{nibPullOpt[0]}}}, {{4{nibPullOpt[1]}}, {4{nibPullOpt[0]}}});
      end
      mixCfg = '{8'h0e, 8'h08, 8'h81};
      cyc(2);
      cmp(mixPad.outEn_b & 8'h0c, 8'h08);
      cmp(mixPad.pullOn, 8'h81);
      mixCfg.outVal = 8'h0c;
      cyc(2);
      cmp(mixPad.outVal & 8'h0c, 8'h00);
      cmp(mixPad.outEn_b & 8'h0c, 8'h0c);
      cmp(mixRd & 8'h0c, 8'h0c);
      audioSel = 1'b1;
      for (int i = 0; i < 2; i++) begin
         audioDacBit = i[0];
         cyc(2);
         cmp(mixPad.outVal & 8'h02, {6'h00, i[0], 1'b0});
      end
      audioSel = 1'b0;
      mixExt = 8'h7f;
      cyc(6);
      cmp(mixRd, 8'h7d);
      edge_irq(8'h7e, 1'b0);
      mfIntEn = 1'b1;
      edge_irq(8'h7f, 1'b0);
      edge_irq(8'h7e, 1'b1);
      edge_irq(8'h5e, 1'b1);
      edge_irq(8'hde, 1'b1);
      edge_irq(8'h5e, 1'b0);
      edge_irq(8'h7f, 1'b0);
      enterIdle = 1'b1;
      cyc(1);
      enterIdle = 1'b0;
      cyc(1);
      cmp(8'(pwrState), 8'(PWR_IDLE));
      mixExt = 8'h5f;
      wait_wake;
      edge_irq(8'h5f, 1'b1);
      mfIntEn = 1'b0;
      wakeOptEn = 8'h10;
      wakeExt = 8'hff;
      enterDown = 1'b1;
      cyc(1);
      enterDown = 1'b0;
      wakeExt = 8'hdf;
      cyc(6);
      cmp(8'(pwrState), 8'(PWR_DOWN));
      wakeExt = 8'hcf;
      wait_wake;
      final_report;
   end
endmodule
